// File: design/sequencer_pkg.sv
// Constants, register map and state encoding of the supply protection sequencer
package sequencer_pkg;

	// Clock and timing
	localparam int CLK_HZ       = 50_000_000;
	localparam int QUAL_TIME_MS = 16;
	localparam int REC_TIME_MS  = 8;
	localparam int REC_MAX_MS   = 9;
	localparam int FILT_TIME_US = 8;
	localparam int QUAL_CYCLES  = QUAL_TIME_MS * (CLK_HZ / 1000);
	localparam int REC_CYCLES   = REC_TIME_MS * (CLK_HZ / 1000);
	localparam int REC_MAX_CYC  = REC_MAX_MS * (CLK_HZ / 1000);
	localparam int FILT_CYCLES  = FILT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int TIMER_W      = 20;
	localparam int FILT_W       = 10;

	// APB register map
	localparam int             APB_AW     = 12;
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;

	// Control register fields
	localparam int         CTRL_HOLD_BIT = 0;
	localparam logic       CTRL_RST      = 1'b0;

	// Event bits, shared by interrupt status and mask
	localparam int         EV_W      = 4;
	localparam int         EV_UV     = 0;
	localparam int         EV_OV     = 1;
	localparam int         EV_OT     = 2;
	localparam int         EV_ON     = 3;
	localparam logic [3:0] MASK_RST  = 4'h0;
	localparam logic [3:0] EV_NONE   = 4'h0;

	// Status register fields
	localparam int ST_STATE_LSB  = 0;
	localparam int ST_SWITCH_BIT = 4;
	localparam int ST_GOOD_BIT   = 5;
	localparam int ST_UV_BIT     = 6;
	localparam int ST_OV_BIT     = 7;
	localparam int ST_OT_BIT     = 8;
	localparam int ST_OSC_BIT    = 9;
	localparam int ST_PIN_BIT    = 10;

	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'b000,
		ST_QUALIFY = 3'b001,
		ST_RECOVER = 3'b010,
		ST_GOOD    = 3'b011,
		ST_THERMAL = 3'b100
	} seq_state_t;

endpackage

// File: design/usb_supply_protection_sequencer.sv
// Sequencer for the pass switch and power-good pin of a USB supply protector
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module usb_supply_protection_sequencer
	import sequencer_pkg::*;
#(
	parameter int QUAL_CYCLES_P = sequencer_pkg::QUAL_CYCLES,
	parameter int REC_CYCLES_P  = sequencer_pkg::REC_CYCLES
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic [sequencer_pkg::APB_AW-1:0] paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Qualified comparator indications
	input  wire logic                          undervoltage_lockout,
	input  wire logic                          overvoltage_lockout,
	input  wire logic [1:0]                    ov_excursion,
	input  wire logic                          overtemp,
	// Host pins
	input  wire logic                          switch_allow_n,
	input  wire logic                          adapter_ok_out_i,
	output logic                               adapter_ok_out_o,
	output logic                               adapter_ok_out_oe,
	// Power stage and interrupt
	output logic                               pass_switch,
	output logic                               osc_run,
	output logic                               charge_pump_en,
	output logic                               irq
);
	import sequencer_pkg::*;

	// One record holds all state so reset and next value stay in step
	typedef struct packed {
		seq_state_t          state;
		logic [TIMER_W-1:0]  timer;
		logic [FILT_W-1:0]   integ;
		logic                ov_trip;
		logic                uv_d;
		logic                ot_d;
		logic                good;
		logic                switch_on;
		logic                hold_off;
		logic [EV_W-1:0]     irq_stat;
		logic [EV_W-1:0]     irq_mask;
		logic [31:0]         rdata;
		logic                osc_on;
		logic                pump_on;
		logic                irq_out;
	} seq_regs_t;

	localparam seq_regs_t REGS_RST = '{
		state:     ST_LOCKOUT,
		timer:     '0,
		integ:     '0,
		ov_trip:   1'b0,
		uv_d:      1'b0,
		ot_d:      1'b0,
		good:      1'b0,
		switch_on: 1'b0,
		hold_off:  CTRL_RST,
		irq_stat:  EV_NONE,
		irq_mask:  MASK_RST,
		rdata:     32'h0000_0000,
		osc_on:    1'b1,
		pump_on:   1'b0,
		irq_out:   1'b0
	};

	// Timers compare against the last count, so expiry lands on the Nth edge
	localparam logic [TIMER_W-1:0] QUAL_LAST = TIMER_W'(QUAL_CYCLES_P - 1);
	localparam logic [TIMER_W-1:0] REC_LAST  = TIMER_W'(REC_CYCLES_P - 1);
	// The integrator saturates at the trip level, so decay starts known
	localparam logic [FILT_W-1:0]  FILT_LIM  = FILT_W'(FILT_CYCLES);

	seq_regs_t regs_reg;
	seq_regs_t regs_next;

	function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
		addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
			(a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
	endfunction

	// True while the input sits between the two lockout levels
	function automatic logic supply_ok(input logic uv, input logic ov);
		supply_ok = !uv && !ov;
	endfunction

	// Rising edge of a level against its registered copy
	function automatic logic edge_up(input logic now, input logic prev);
		edge_up = now && !prev;
	endfunction

	function automatic logic [31:0] read_mux(input logic [APB_AW-1:0] a,
			input seq_regs_t r, input logic pin);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			ADDR_CTRL: begin
				d[CTRL_HOLD_BIT] = r.hold_off;
			end
			ADDR_STATUS: begin
				d[ST_STATE_LSB +: 3] = r.state;
				d[ST_SWITCH_BIT]     = r.switch_on;
				d[ST_GOOD_BIT]       = r.good;
				d[ST_UV_BIT]         = r.uv_d;
				d[ST_OV_BIT]         = r.ov_trip;
				d[ST_OT_BIT]         = r.ot_d;
				d[ST_OSC_BIT]        = r.osc_on;
				d[ST_PIN_BIT]        = pin;
			end
			ADDR_IRQ_STAT: begin
				d[EV_W-1:0] = r.irq_stat;
			end
			ADDR_IRQ_MASK: begin
				d[EV_W-1:0] = r.irq_mask;
			end
			default: begin
				d = 32'h0000_0000;
			end
		endcase
		return d;
	endfunction

	logic                wr_access;
	logic [FILT_W-1:0]   step;
	logic [FILT_W:0]     integ_sum;
	logic                ov_trip_now;
	logic                in_range;
	logic [EV_W-1:0]     events;
	logic [EV_W-1:0]     w1c;

	always_comb begin
		regs_next = regs_reg;
		wr_access = psel && penable && pwrite && addr_mapped(paddr);
		step      = FILT_W'(ov_excursion) + FILT_W'(1);
		integ_sum = {1'b0, regs_reg.integ} + {1'b0, step};
		events    = EV_NONE;
		w1c       = EV_NONE;

		// Larger excursions add bigger steps, so the trip comes sooner
		if (overvoltage_lockout) begin
			if (integ_sum >= {1'b0, FILT_LIM}) begin
				regs_next.integ   = FILT_LIM;
				regs_next.ov_trip = 1'b1;
			end else begin
				regs_next.integ = integ_sum[FILT_W-1:0];
			end
		end else begin
			regs_next.ov_trip = 1'b0;
			if (regs_reg.integ != '0) begin
				regs_next.integ = regs_reg.integ - FILT_W'(1);
			end
		end
		ov_trip_now = regs_next.ov_trip;
		in_range    = supply_ok(undervoltage_lockout, overvoltage_lockout);

		case (regs_reg.state)
			ST_LOCKOUT: begin
				regs_next.timer = '0;
				if (!undervoltage_lockout) begin
					regs_next.state = ST_QUALIFY;
				end
			end
			ST_QUALIFY: begin
				// Raw overvoltage also restarts the wait: a deglitch
				if (!in_range) begin
					regs_next.timer = '0;
				end else if (regs_reg.timer == QUAL_LAST) begin
					regs_next.timer = '0;
					regs_next.state = overtemp ? ST_THERMAL : ST_GOOD;
				end else begin
					regs_next.timer = regs_reg.timer + TIMER_W'(1);
				end
			end
			ST_RECOVER: begin
				// Same restart rule as qualification, shorter wait
				if (!in_range) begin
					regs_next.timer = '0;
				end else if (regs_reg.timer == REC_LAST) begin
					regs_next.timer = '0;
					regs_next.state = overtemp ? ST_THERMAL : ST_GOOD;
				end else begin
					regs_next.timer = regs_reg.timer + TIMER_W'(1);
				end
			end
			ST_GOOD: begin
				regs_next.timer = '0;
				if (overtemp) begin
					regs_next.state = ST_THERMAL;
				end
			end
			ST_THERMAL: begin
				// Sensor hysteresis is outside; low here means cooled
				regs_next.timer = '0;
				if (!overtemp) begin
					regs_next.state = ST_GOOD;
				end
			end
			default: begin
				regs_next.timer = '0;
				regs_next.state = ST_LOCKOUT;
			end
		endcase

		// Supply faults override every state in the same cycle
		if (undervoltage_lockout) begin
			regs_next.state = ST_LOCKOUT;
			regs_next.timer = '0;
		end else if (ov_trip_now) begin
			regs_next.state = ST_RECOVER;
			regs_next.timer = '0;
		end

		// Power-good ignores switch-allow; only faults release it
		regs_next.good      = (regs_next.state == ST_GOOD);
		regs_next.switch_on = regs_next.good && !switch_allow_n &&
			!regs_reg.hold_off;
		regs_next.uv_d      = undervoltage_lockout;
		regs_next.ot_d      = overtemp;
		// Output flops take their next values here so pins never glitch
		regs_next.osc_on    = supply_ok(regs_next.uv_d,
			regs_next.ov_trip);
		regs_next.pump_on   = regs_next.switch_on &&
			regs_next.osc_on;

		// Each event is an edge against the registered view, so it sets once
		events[EV_UV] = edge_up(undervoltage_lockout, regs_reg.uv_d);
		events[EV_OV] = edge_up(ov_trip_now, regs_reg.ov_trip);
		events[EV_OT] = edge_up(overtemp, regs_reg.ot_d);
		events[EV_ON] = edge_up(regs_next.switch_on, regs_reg.switch_on);

		// Writes land in the access cycle; status and unmapped are dropped
		if (wr_access) begin
			case (paddr)
				ADDR_CTRL: begin
					// Gates only the switch, never power-good
					regs_next.hold_off = pwdata[CTRL_HOLD_BIT];
				end
				ADDR_IRQ_STAT: begin
					w1c = pwdata[EV_W-1:0];
				end
				ADDR_IRQ_MASK: begin
					regs_next.irq_mask = pwdata[EV_W-1:0];
				end
				default: begin
					w1c = EV_NONE;
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		regs_next.irq_stat = (regs_reg.irq_stat & ~w1c) | events;
		regs_next.irq_out  = |(regs_next.irq_stat & regs_next.irq_mask);

		// Read data is captured in the setup phase so pready can stay high
		if (psel && !penable && !pwrite) begin
			regs_next.rdata = read_mux(paddr, regs_reg, adapter_ok_out_i);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_reg <= REGS_RST;
		end else begin
			regs_reg <= regs_next;
		end
	end

	assign prdata            = regs_reg.rdata;
	assign pready            = 1'b1;
	// Unmapped offsets answer with an error but never stall
	assign pslverr           = psel && penable && !addr_mapped(paddr);
	// Open-drain: the pin is only ever pulled low
	assign adapter_ok_out_o  = 1'b0;
	assign adapter_ok_out_oe = regs_reg.good;
	assign pass_switch       = regs_reg.switch_on;
	assign osc_run           = regs_reg.osc_on;
	assign charge_pump_en    = regs_reg.pump_on;
	assign irq               = regs_reg.irq_out;

endmodule

// File: verification/seq_properties.sv
// Pin-level assertions for the supply protection sequencer
`timescale 1ns/1ps
module seq_properties
	import sequencer_pkg::*;
#(
	parameter int QUAL_CYCLES_P = 20,
	parameter int REC_CYCLES_P  = 10
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Indications
	input wire logic undervoltage_lockout,
	input wire logic overvoltage_lockout,
	input wire logic overtemp,
	input wire logic switch_allow_n,
	// Outputs
	input wire logic adapter_ok_out_oe,
	input wire logic pass_switch,
	input wire logic osc_run,
	input wire logic charge_pump_en
);
	// Undervoltage stays remembered until good, so it demands the long wait
	logic [19:0] run;
	logic [9:0]  ov_run;
	logic        uv_last;
	int          need;
	assign need = uv_last ? QUAL_CYCLES_P : REC_CYCLES_P;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run     <= '0;
			ov_run  <= '0;
			uv_last <= 1'b1;
		end else begin
			run     <= (undervoltage_lockout || overvoltage_lockout) ?
				'0 : run + 20'h1;
			ov_run  <= overvoltage_lockout ? ov_run + {9'h0, ~&ov_run} : '0;
			if (undervoltage_lockout)
				uv_last <= 1'b1;
			else if (adapter_ok_out_oe)
				uv_last <= 1'b0;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_uv_off: assert property (undervoltage_lockout |=>
		!adapter_ok_out_oe && !pass_switch) else $error("uv left on");
	chk_osc_stop: assert property (undervoltage_lockout |=>
		!osc_run && !charge_pump_en) else $error("osc runs in uv");
	chk_pump_gate: assert property (charge_pump_en |->
		pass_switch && osc_run && !$past(switch_allow_n) &&
		!$past(undervoltage_lockout)) else $error("pump enable wrong");
	chk_ot_off: assert property (overtemp ##1 overtemp |=>
		!pass_switch && !adapter_ok_out_oe) else $error("hot, still on");
	chk_allow_off: assert property (switch_allow_n |=>
		!pass_switch) else $error("switch closed while not allowed");
	chk_switch_good: assert property (pass_switch |->
		adapter_ok_out_oe) else $error("switch on without good");
	chk_on_early: assert property ($rose(adapter_ok_out_oe) |->
		run >= need) else $error("good came too early");
	chk_on_late: assert property (run == need + 3 && !overtemp &&
		!$past(overtemp) |-> adapter_ok_out_oe) else $error("good late");
	chk_ov_trip: assert property (ov_run > FILT_CYCLES |->
		!osc_run && !pass_switch && !adapter_ok_out_oe)
		else $error("overvoltage not tripped in time");
endmodule
bind usb_supply_protection_sequencer seq_properties #(
	.QUAL_CYCLES_P(QUAL_CYCLES_P), .REC_CYCLES_P(REC_CYCLES_P)
) i_props (.pclk(pclk), .presetn(presetn),
	.undervoltage_lockout(undervoltage_lockout),
	.overvoltage_lockout(overvoltage_lockout), .overtemp(overtemp),
	.switch_allow_n(switch_allow_n), .adapter_ok_out_oe(adapter_ok_out_oe),
	.pass_switch(pass_switch), .osc_run(osc_run),
	.charge_pump_en(charge_pump_en));

// File: verification/host_model.sv
// Host side: switch-allow driver and pulled-up power-good line
`timescale 1ns/1ps
module host_model (
	// From bench
	input  wire logic allow_req,
	// Device pin
	input  wire logic adapter_ok_out_o,
	input  wire logic adapter_ok_out_oe,
	output logic      switch_allow_n,
	output logic      pin_level
);
	assign switch_allow_n = !allow_req;
	// Released line floats up through the pull-up, never holds old level
	assign pin_level = adapter_ok_out_oe ? adapter_ok_out_o : 1'b1;
endmodule

// File: verification/usb_supply_protection_sequencer_tb.sv
// Self-checking bench for the supply protection sequencer
`timescale 1ns/1ps
module usb_supply_protection_sequencer_tb;
	import sequencer_pkg::*;
	localparam int Q = 20;
	localparam int R = 10;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, uv = 1'b1, ov = 1'b0, ot = 1'b0, allow = 1'b1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [1:0]  exc = '0;
	logic        pready, pslverr, sw_n, pin, o, oe, sw, osc, cp, irq, re;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          n;
	always #10 pclk = ~pclk;
	usb_supply_protection_sequencer #(.QUAL_CYCLES_P(Q), .REC_CYCLES_P(R))
	i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.undervoltage_lockout(uv), .overvoltage_lockout(ov),
		.ov_excursion(exc), .overtemp(ot), .switch_allow_n(sw_n),
		.adapter_ok_out_i(pin), .adapter_ok_out_o(o),
		.adapter_ok_out_oe(oe), .pass_switch(sw), .osc_run(osc),
		.charge_pump_en(cp), .irq(irq));
	host_model i_host (.allow_req(allow), .adapter_ok_out_o(o),
		.adapter_ok_out_oe(oe), .switch_allow_n(sw_n), .pin_level(pin));
	task automatic check(input logic [31:0] s, input logic [31:0] e,
		input string w);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Leading edge keeps back-to-back calls from driving psel twice at once
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			miscompares++;
			wrap_up();
		end
	endtask
	// Counts edges until the pin or the switch reaches a level
	task automatic wait_on(input bit k, input logic v);
		for (n = 0; n < 2000; n++) begin
			@(negedge pclk);
			if ((k ? sw : oe) === v)
				break;
		end
		if (n == 2000) begin
			miscompares++;
			wrap_up();
		end
		@(posedge pclk);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		uv <= 1'b0;
		wait_on(0, 1'b1);
		check(32'(n), Q + 1, "qualify");
		check({sw, pin}, 2'h2, "switch and pin");
		apb(0, ADDR_STATUS, 32'h0);
		check(rd, 32'h233, "status");
		apb(0, 12'h010, 32'h0);
		check({re, rd[30:0]}, 32'h8000_0000, "unmapped");
		apb(1, ADDR_CTRL, 32'h1);
		repeat (2) @(posedge pclk);
		check({sw, oe}, 2'h1, "hold off");
		apb(0, ADDR_CTRL, 32'h0);
		check({re, rd[30:0]}, 32'h1, "ctrl readback");
		apb(1, ADDR_CTRL, 32'h0);
		allow <= 1'b0;
		repeat (2) @(posedge pclk);
		check({sw, oe}, 2'h1, "allow off");
		allow <= 1'b1;
		repeat (2) @(posedge pclk);
		check({sw, cp}, 2'h3, "allow on");
		ov <= 1'b1;
		repeat (50) @(posedge pclk);
		ov <= 1'b0;
		repeat (2) @(posedge pclk);
		check(sw, 1'h1, "short glitch");
		exc <= 2'h3;
		ov  <= 1'b1;
		wait_on(1, 1'b0);
		check(32'(n <= 100), 1'h1, "trip time");
		repeat (400) @(posedge pclk);
		check({osc, cp, pin}, 3'h1, "ov off");
		ov <= 1'b0;
		wait_on(0, 1'b1);
		check(32'(n >= R && n <= R + 2), 1'h1, "recover");
		uv <= 1'b1;
		repeat (2) @(posedge pclk);
		check({sw, oe, osc}, 3'h0, "uv off");
		uv <= 1'b0;
		repeat (10) @(posedge pclk);
		uv <= 1'b1;
		@(posedge pclk);
		uv <= 1'b0;
		wait_on(0, 1'b1);
		check(32'(n), Q + 1, "requalify");
		apb(0, ADDR_IRQ_STAT, 32'h0);
		check(rd, 32'hb, "events");
		apb(1, ADDR_IRQ_STAT, 32'hf);
		apb(1, ADDR_IRQ_MASK, 32'h4);
		apb(0, ADDR_IRQ_MASK, 32'h0);
		check({re, rd[30:0]}, 32'h4, "mask");
		ot <= 1'b1;
		repeat (3) @(posedge pclk);
		check({sw, pin, irq}, 3'h3, "thermal");
		apb(1, ADDR_IRQ_STAT, 32'h4);
		repeat (2) @(posedge pclk);
		check(irq, 1'h0, "irq clear");
		allow <= 1'b0;
		ot    <= 1'b0;
		repeat (3) @(posedge pclk);
		check({sw, oe}, 2'h1, "cool, held");
		allow <= 1'b1;
		repeat (2) @(posedge pclk);
		check(sw, 1'h1, "cool");
		wrap_up();
	end
endmodule
